// File: src/electrode_regs_pkg.sv
/*
 * Package for the electrode detection register bank: register offsets,
 * field positions, reset values and modulator clock divider counts.
 * Assumes an APB master with 32-bit data and byte addressing.
 */
package electrode_regs_pkg;

    // printed offsets are not multiples of four: they are word indices
    localparam logic [7:0] IDX_DETECT_SELECT = 8'h07;
    localparam logic [7:0] IDX_STATUS = 8'h08;
    localparam logic [7:0] IDX_RESP_ONE = 8'h09;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h0a;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h0b;

    localparam int DETECT_EN_LSB = 0;
    localparam int CH1_REVERSE_BIT = 4;
    localparam int CH2_REVERSE_BIT = 5;
    localparam logic [7:0] DETECT_SELECT_WMASK = 8'h3f;

    localparam int BIAS_STATUS_BIT = 4;
    localparam int CLK_DIV_BIT = 6;
    localparam logic [7:0] STATUS_WMASK = 8'h40;

    localparam int RESP_DEMOD_BIT = 7;
    localparam int RESP_MOD_BIT = 6;
    localparam int RESP_PHASE_LSB = 2;
    localparam int RESP_FIXED_BIT = 1;
    localparam int RESP_CLKSRC_BIT = 0;
    localparam logic [7:0] RESP_WMASK = 8'hfd;

    localparam logic [7:0] DETECT_SELECT_RESET = 8'h00;
    localparam logic [7:0] CLK_DIV_RESET = 8'h00;
    localparam logic [7:0] RESP_ONE_RESET = 8'h02;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

    localparam logic [4:0] DIV_SLOW_COUNT = 5'h04;
    localparam logic [4:0] DIV_FAST_COUNT = 5'h10;

endpackage : electrode_regs_pkg

// File: src/electrode_detect_control_regs.sv
/*
 * Electrode lead-off control and status registers behind an APB slave,
 * modulator clock enable divider and lead-off change interrupt.
 * Assumes the analog comparators drive lead_off_raw and bias_off_raw
 * asynchronously; they are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RQ1] software writes zero to the top two bits of the select register
// [RQ2] bits 5 and 4 reverse excitation current of channel 2 and 1
// [RQ3] select bits 3..0 enable ch2 neg, ch2 pos, ch1 neg, ch1 pos detection
// [RQ4] status register at index 08h reports each electrode's connection
// [RQ5] flag reads 0 when attached, 1 when lead is off; resets to 0
// [RQ6] software ignores a flag whose detection enable is clear
// [RQ7] status bit 6 selects modulator clock: divide by 4 or by 16
// [RQ8] status bit 4 shows bias-drive electrode off, read only
// [RQ9] status bits 3..0 flag ch2 neg, ch2 pos, ch1 neg, ch1 pos off
// [RQ10] respiration register at 09h holds demod, mod, phase, fixed one, clock source
// [RQ11] variants without respiration have software write 02h there
// [RQ12] select register at index 07h picks inputs for lead-off detection
// [RQ13] writes to read-only status flags are ignored
module electrode_detect_control_regs
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] lead_off_raw,
    input wire logic bias_off_raw,
    output logic [3:0] detect_enable,
    output logic ch1_current_reverse,
    output logic ch2_current_reverse,
    output logic mod_clk_en,
    output logic breath_demodulator_on,
    output logic breath_modulator_on,
    output logic [3:0] breath_phase_select,
    output logic breath_clock_source,
    output logic irq
);

    typedef struct packed {
        logic [7:0] detect_select;
        logic clk_div_sel;
        logic [7:0] resp_one;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] flags;
        logic [4:0] irq_status;
        logic [4:0] irq_mask;
        logic [4:0] div_count;
        logic mod_clk_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [7:0] word_idx;
    logic addr_ok;
    logic access;
    logic wr;
    logic [7:0] status_view;
    logic [7:0] rd_byte;
    logic [4:0] div_limit;
    logic [4:0] change;

    always_comb
    begin
        state_next = state_reg;
        word_idx = paddr[9:2];
        addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
        access = psel && penable && !state_reg.pready;
        wr = access && pwrite && pstrb[0];
        status_view = 8'h00;
        status_view[electrode_regs_pkg::CLK_DIV_BIT] = state_reg.clk_div_sel;
        status_view[electrode_regs_pkg::BIAS_STATUS_BIT] = state_reg.flags[4]; // [RQ8]
        status_view[3:0] = state_reg.flags[3:0]; // [RQ4] [RQ5] [RQ9]
        rd_byte = 8'h00;

        // two-flop synchroniser; only the second stage is used
        state_next.sync1 = {bias_off_raw, lead_off_raw};
        state_next.sync2 = state_reg.sync1;
        state_next.flags = state_reg.sync2; // [RQ5] 1 means detached
        change = state_reg.sync2 ^ state_reg.flags;

        // modulator clock enable: divide by 4 or by 16
        div_limit = state_reg.clk_div_sel ? electrode_regs_pkg::DIV_FAST_COUNT
                                          : electrode_regs_pkg::DIV_SLOW_COUNT; // [RQ7]
        if (state_reg.div_count >= div_limit - 5'h01)
        begin
            state_next.div_count = 5'h00;
            state_next.mod_clk_en = 1'b1;
        end
        else
        begin
            state_next.div_count = state_reg.div_count + 5'h01;
            state_next.mod_clk_en = 1'b0;
        end

        // apb slave: one wait state, answer in the second access cycle
        state_next.pready = access;
        state_next.pslverr = 1'b0;
        if (access)
        begin
            case (word_idx)
                electrode_regs_pkg::IDX_DETECT_SELECT: rd_byte = state_reg.detect_select; // [RQ12]
                electrode_regs_pkg::IDX_STATUS: rd_byte = status_view;
                electrode_regs_pkg::IDX_RESP_ONE: rd_byte = state_reg.resp_one; // [RQ10]
                electrode_regs_pkg::IDX_IRQ_STATUS: rd_byte = {3'b000, state_reg.irq_status};
                electrode_regs_pkg::IDX_IRQ_MASK: rd_byte = {3'b000, state_reg.irq_mask};
                default: state_next.pslverr = 1'b1;
            endcase
            if (!addr_ok)
            begin
                state_next.pslverr = 1'b1;
                rd_byte = 8'h00;
            end
            state_next.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end

        if (wr && addr_ok)
        begin
            case (word_idx)
                electrode_regs_pkg::IDX_DETECT_SELECT:
                    // top two bits held at zero [RQ1] [RQ2] [RQ3] [RQ12]
                    state_next.detect_select = pwdata[7:0] & electrode_regs_pkg::DETECT_SELECT_WMASK;
                electrode_regs_pkg::IDX_STATUS:
                    state_next.clk_div_sel = pwdata[electrode_regs_pkg::CLK_DIV_BIT]; // [RQ7] [RQ13] flags untouched
                electrode_regs_pkg::IDX_RESP_ONE:
                    // bit 1 always reads one [RQ10] [RQ11]
                    state_next.resp_one = (pwdata[7:0] & electrode_regs_pkg::RESP_WMASK)
                                          | electrode_regs_pkg::RESP_ONE_RESET;
                electrode_regs_pkg::IDX_IRQ_STATUS:
                    state_next.irq_status = state_reg.irq_status & ~pwdata[4:0];
                electrode_regs_pkg::IDX_IRQ_MASK:
                    state_next.irq_mask = pwdata[4:0];
                default:
                    state_next.irq_mask = state_next.irq_mask;
            endcase
        end

        // any flag change is an event; set wins over a same-cycle clear
        state_next.irq_status = state_next.irq_status | change;
        state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg.detect_select <= electrode_regs_pkg::DETECT_SELECT_RESET;
            state_reg.clk_div_sel <= electrode_regs_pkg::CLK_DIV_RESET[0];
            state_reg.resp_one <= electrode_regs_pkg::RESP_ONE_RESET;
            state_reg.sync1 <= 5'h00;
            state_reg.sync2 <= 5'h00;
            state_reg.flags <= 5'h00;
            state_reg.irq_status <= 5'h00;
            state_reg.irq_mask <= electrode_regs_pkg::IRQ_MASK_RESET;
            state_reg.div_count <= 5'h00;
            state_reg.mod_clk_en <= 1'b0;
            state_reg.prdata <= 32'h0000_0000;
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
            state_reg.irq <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign detect_enable = state_reg.detect_select[3:0]; // [RQ3]
    assign ch1_current_reverse = state_reg.detect_select[electrode_regs_pkg::CH1_REVERSE_BIT]; // [RQ2]
    assign ch2_current_reverse = state_reg.detect_select[electrode_regs_pkg::CH2_REVERSE_BIT]; // [RQ2]
    assign mod_clk_en = state_reg.mod_clk_en;
    assign breath_demodulator_on = state_reg.resp_one[electrode_regs_pkg::RESP_DEMOD_BIT];
    assign breath_modulator_on = state_reg.resp_one[electrode_regs_pkg::RESP_MOD_BIT];
    assign breath_phase_select = state_reg.resp_one[electrode_regs_pkg::RESP_PHASE_LSB +: 4];
    assign breath_clock_source = state_reg.resp_one[electrode_regs_pkg::RESP_CLKSRC_BIT];
    assign irq = state_reg.irq;

endmodule : electrode_detect_control_regs

`default_nettype wire

// File: testbench/electrode_detect_control_regs_properties.sv
/* concurrent checks on the electrode register bank ports
   bound to the bank from the bench top file */
`timescale 1ns/1ps
`default_nettype none
module electrode_detect_control_regs_properties
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] detect_enable,
    input wire logic ch1_current_reverse,
    input wire logic ch2_current_reverse,
    input wire logic mod_clk_en,
    input wire logic breath_demodulator_on,
    input wire logic breath_modulator_on,
    input wire logic [3:0] breath_phase_select,
    input wire logic breath_clock_source
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire take = psel && penable && !pready;
    wire wr = take && pwrite && pstrb[0];
    wire bad = paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0 || paddr[9:2] < 8'h07 || paddr[9:2] > 8'h0b;
    property p_answer; take |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after one wait state");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_refuse; take && bad |=> pslverr && prdata == 32'h0; endproperty
    a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
    property p_enable; wr && paddr == 12'h01c |=> detect_enable == $past(pwdata[3:0]); endproperty
    a_enable: assert property (p_enable) else $error("detect enables wrong");
    property p_rev; wr && paddr == 12'h01c |=> {ch2_current_reverse, ch1_current_reverse} == $past(pwdata[5:4]);
    endproperty
    a_rev: assert property (p_rev) else $error("current reverse wrong");
    property p_resp; wr && paddr == 12'h024 |=> {breath_demodulator_on, breath_modulator_on, breath_phase_select,
        breath_clock_source} == {$past(pwdata[7:2]), $past(pwdata[0])}; endproperty
    a_resp: assert property (p_resp) else $error("respiration fields wrong");
    property p_mod; mod_clk_en |-> ##[1:16] mod_clk_en; endproperty
    a_mod: assert property (p_mod) else $error("modulator pulse late");
endmodule : electrode_detect_control_regs_properties
`default_nettype wire

// File: testbench/electrode_detect_control_regs_bench.sv
/* self-checking bench for the electrode register bank over apb
   needs the bank and its properties checker compiled first */
`timescale 1ns/1ps
`default_nettype none
module electrode_detect_control_regs_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bias_off_raw = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf, lead_off_raw = 4'h0, detect_enable, ph;
    logic pready, pslverr, rev1, rev2, mclk, dmo, mo, cs, irq;
    logic [11:0] ra [4] = '{12'h01c, 12'h020, 12'h024, 12'h02c};
    logic [31:0] rv [4] = '{32'h0, 32'h0, 32'h2, 32'h0};
    int n_fail = 0, checks = 0, cyc = 0, t;
    always #20 pclk = ~pclk;
    electrode_detect_control_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .lead_off_raw, .bias_off_raw, .detect_enable, .ch1_current_reverse(rev1),
        .ch2_current_reverse(rev2), .mod_clk_en(mclk), .breath_demodulator_on(dmo), .breath_modulator_on(mo),
        .breath_phase_select(ph), .breath_clock_source(cs), .irq);
    task automatic finish_test;
        $display("fails %0d checks %0d", n_fail, checks);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic period(input int exp);
        t = 0;
        do @(posedge pclk); while (mclk !== 1'b1);
        do
        begin
            @(posedge pclk);
            t++;
        end
        while (mclk !== 1'b1);
        chk(t, exp);
    endtask : period
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            finish_test;
        end
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i])
        begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, rv[i]);
        end
        apb(1'b1, 12'h01c, 32'hff);
        apb(1'b0, 12'h01c, 32'h0);
        chk(rd, 32'h3f);
        apb(1'b1, 12'h01c, 32'h15);
        chk({rev2, rev1, detect_enable}, 32'h15);
        lead_off_raw <= 4'ha;
        bias_off_raw <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(irq, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 32'h1a);
        chk({28'h0, rd[3:0] & detect_enable}, 32'h0);
        apb(1'b1, 12'h020, 32'h5f);
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 32'h5a);
        period(16);
        apb(1'b1, 12'h020, 32'h0);
        period(4);
        apb(1'b1, 12'h02c, 32'h1f);
        repeat (2) @(posedge pclk);
        chk(irq, 32'h1);
        apb(1'b1, 12'h028, 32'h1f);
        repeat (2) @(posedge pclk);
        chk(irq, 32'h0);
        bias_off_raw <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, 12'h028, 32'h0);
        chk({irq, rd[30:0]}, 32'h80000010);
        apb(1'b1, 12'h024, 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, 12'h024, 32'hfd);
        chk({dmo, mo, ph, cs}, 32'h7f);
        apb(1'b0, 12'h030, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h01d, 32'h0);
        chk(err, 32'h1);
        pstrb <= 4'h0;
        apb(1'b1, 12'h01c, 32'h0);
        pstrb <= 4'hf;
        apb(1'b0, 12'h01c, 32'h0);
        chk(rd, 32'h15);
        finish_test;
    end
endmodule : electrode_detect_control_regs_bench
bind electrode_detect_control_regs electrode_detect_control_regs_properties u_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .detect_enable, .ch1_current_reverse,
    .ch2_current_reverse, .mod_clk_en, .breath_demodulator_on, .breath_modulator_on, .breath_phase_select,
    .breath_clock_source);
`default_nettype wire
